/* File: lock_delay_pkg.sv */
// Purpose: Constants for the loop lock detector and digital delay block
// Assumes: APB register access, 32-bit data, one 125 MHz clock
// Notes: Register offsets are byte addresses
// How it works
// - Second-loop prescaler accepts integers 2 through 8.
// - Second-loop feedback divider accepts integers 1 through 263143.
// - Total second-loop feedback divide is prescaler times feedback divider.
// - Calibration divider normally equals feedback divider; ignored with external oscillator.
// - Four events: first-loop lock, second-loop lock, holdover exit, resync pulse with half-step bit set.
// - Lock event only after lock-count in-window phase-detector cycles.
// - An out-of-window cycle clears the running count to zero.
// - A loop lock event raises that loop's lock indication.
// - Holdover exit event makes the device leave holdover.
// - Smallest delay step is half a distribution clock period.
// - Effective delay equals delay count minus half the half-step bit.
// - Qualifying clock is the output picked by the feedback selector.
// - Relative delay: each resync with same value shifts again.
// - Dynamic delay changes offsets without stopping the outputs.
package lock_delay_pkg;
   localparam int unsigned PRESCALER_MIN = 2;
   localparam int unsigned PRESCALER_MAX = 8;
   localparam int unsigned FB_DIV_MIN = 1;
   localparam int unsigned FB_DIV_MAX = 263143;
   localparam int PRESC_W = 4;
   localparam int FBDIV_W = 19;
   localparam int TOTAL_W = PRESC_W + FBDIV_W;
   localparam int CNT_W = 16;
   localparam int WND_W = 8;
   localparam int DLY_W = 10;
   localparam int SEL_W = 3;
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_PRESC = 8'h04;
   localparam logic [7:0] A_FBDIV = 8'h08;
   localparam logic [7:0] A_CALDIV = 8'h0C;
   localparam logic [7:0] A_WND = 8'h10;
   localparam logic [7:0] A_CNT1 = 8'h14;
   localparam logic [7:0] A_CNT2 = 8'h18;
   localparam logic [7:0] A_CNTH = 8'h1C;
   localparam logic [7:0] A_DELAY = 8'h20;
   localparam logic [7:0] A_TOTAL = 8'h24;
   localparam logic [7:0] A_STAT = 8'h28;
   localparam logic [7:0] A_IRQ = 8'h2C;
   localparam logic [7:0] A_MASK = 8'h30;
   localparam int CTRL_EXTVCO = 0;
   localparam int CTRL_HOLD = 1;
   localparam int CTRL_RESYNC = 2;
   localparam int DLY_HS = 10;
   localparam int DLY_SEL = 11;
   localparam int IRQ_W = 4;
   localparam logic [PRESC_W-1:0] PRESC_RST = 4'h2;
   localparam logic [FBDIV_W-1:0] FBDIV_RST = 19'h00001;
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0400;
   localparam logic [WND_W-1:0] WND_RST = 8'h04;
   typedef enum logic [1:0] {
      DLY_IDLE = 2'b00,
      DLY_WAIT = 2'b01,
      DLY_APPLY = 2'b10
   } dly_state_t;
endpackage

/* File: lock_delay.sv */
// Purpose: Digital lock detect, divider check and dynamic digital delay
// Assumes: Phase-detector edge pulses arrive from other clock domains as levels toggling per cycle
// Notes: Edge-error inputs are per-cycle window error magnitudes in clk_i ticks
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
module lock_delay #(
   parameter int NLOOP_CNT_W = lock_delay_pkg::CNT_W
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic [1:0] pd_tick_i,
   input wire logic [2*lock_delay_pkg::WND_W-1:0] pd_err_i,
   input wire logic dist_half_tick_i,
   output logic first_lock_o,
   output logic second_lock_o,
   output logic holdover_o,
   output logic [lock_delay_pkg::TOTAL_W-1:0] total_div_o,
   output logic div_err_o,
   output logic [lock_delay_pkg::SEL_W-1:0] qual_sel_o,
   output logic resync_o,
   output logic irq_o
);
   import lock_delay_pkg::*;

   logic [31:0] ctrl_reg, presc_reg, fbdiv_reg, caldiv_reg, wnd_reg, dly_reg;
   logic [CNT_W-1:0] cnt1_reg, cnt2_reg, cnth_reg;
   logic [IRQ_W-1:0] irq_reg, mask_reg, ev;
   logic [2:0] tick_s0, tick_s1, tick_s2;
   logic [1:0] tick_prev;
   logic [1:0] run_ok;
   logic [CNT_W-1:0] run_reg [2];
   logic [1:0] lock_reg;
   logic hold_exit;
   logic [DLY_W+1:0] half_left_reg;
   dly_state_t dst_reg;
   logic wr, rd;
   logic irq_clr;

   assign wr = psel_i && penable_i && pwrite_i;
   assign rd = psel_i && penable_i && !pwrite_i;
   // Read of the event register in its access phase clears it
   assign irq_clr = rd && paddr_i == A_IRQ && pready_o;

   function automatic logic in_range(input logic [31:0] v, input int unsigned lo, input int unsigned hi);
      in_range = (v >= lo) && (v <= hi);
   endfunction

   // Register writes
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_reg <= 32'h0;
         presc_reg <= {28'h0, PRESC_RST};
         fbdiv_reg <= {13'h0, FBDIV_RST};
         caldiv_reg <= {13'h0, FBDIV_RST};
         wnd_reg <= {16'h0, WND_RST, WND_RST};
         cnt1_reg <= CNT_RST;
         cnt2_reg <= CNT_RST;
         cnth_reg <= CNT_RST;
         dly_reg <= 32'h0;
         mask_reg <= '0;
      end else if (wr) begin
         case (paddr_i)
            A_CTRL: ctrl_reg <= pwdata_i;
            A_PRESC: if (in_range(pwdata_i, PRESCALER_MIN, PRESCALER_MAX)) presc_reg <= pwdata_i;
            A_FBDIV: if (in_range(pwdata_i, FB_DIV_MIN, FB_DIV_MAX)) fbdiv_reg <= pwdata_i;
            A_CALDIV: if (in_range(pwdata_i, FB_DIV_MIN, FB_DIV_MAX)) caldiv_reg <= pwdata_i;
            A_WND: wnd_reg <= pwdata_i;
            A_CNT1: cnt1_reg <= pwdata_i[CNT_W-1:0];
            A_CNT2: cnt2_reg <= pwdata_i[CNT_W-1:0];
            A_CNTH: cnth_reg <= pwdata_i[CNT_W-1:0];
            A_DELAY: dly_reg <= pwdata_i;
            A_MASK: mask_reg <= pwdata_i[IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // Bus answer: one wait-free access phase
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         prdata_o <= 32'h0;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
      end else begin
         pready_o <= psel_i && !penable_i;
         pslverr_o <= 1'b0;
         if (psel_i && !penable_i && !pwrite_i) begin
            case (paddr_i)
               A_CTRL: prdata_o <= ctrl_reg;
               A_PRESC: prdata_o <= presc_reg;
               A_FBDIV: prdata_o <= fbdiv_reg;
               A_CALDIV: prdata_o <= caldiv_reg;
               A_WND: prdata_o <= wnd_reg;
               A_CNT1: prdata_o <= {16'h0, cnt1_reg};
               A_CNT2: prdata_o <= {16'h0, cnt2_reg};
               A_CNTH: prdata_o <= {16'h0, cnth_reg};
               A_DELAY: prdata_o <= dly_reg;
               A_TOTAL: prdata_o <= {9'h0, total_div_o};
               A_STAT: prdata_o <= {28'h0, div_err_o, holdover_o, second_lock_o, first_lock_o};
               A_IRQ: prdata_o <= {28'h0, irq_reg};
               A_MASK: prdata_o <= {28'h0, mask_reg};
               default: prdata_o <= 32'h0;
            endcase
            pslverr_o <= (paddr_i > A_MASK) || (paddr_i[1:0] != 2'b00);
         end
      end
   end

   // Total divide and calibration divider check
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         total_div_o <= '0;
         div_err_o <= 1'b0;
      end else begin
         // Operands widened first so the product keeps all its bits
         total_div_o <= TOTAL_W'(presc_reg[PRESC_W-1:0]) * TOTAL_W'(fbdiv_reg[FBDIV_W-1:0]);
         div_err_o <= !ctrl_reg[CTRL_EXTVCO] && (caldiv_reg != fbdiv_reg);
      end
   end

   // Phase-detector tick synchronisers: three stages, stage two and three agree
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tick_s0 <= '0;
         tick_s1 <= '0;
         tick_s2 <= '0;
         tick_prev <= '0;
      end else begin
         tick_s0 <= {dist_half_tick_i, pd_tick_i};
         tick_s1 <= tick_s0;
         tick_s2 <= tick_s1;
         for (int i = 0; i < 2; i++) begin
            if (tick_s1[i] == tick_s2[i])
               tick_prev[i] <= tick_s2[i];
         end
      end
   end

   logic [1:0] pd_cyc;
   logic dist_tick;
   logic dist_prev;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) dist_prev <= 1'b0;
      else if (tick_s1[2] == tick_s2[2]) dist_prev <= tick_s2[2];
   end
   assign dist_tick = (tick_s1[2] == tick_s2[2]) && (tick_s2[2] != dist_prev);

   // Running in-window counters, one per loop
   generate
      for (genvar g = 0; g < 2; g++) begin : loop_g
         assign pd_cyc[g] = (tick_s1[g] == tick_s2[g]) && (tick_s2[g] != tick_prev[g]);
         assign run_ok[g] = pd_err_i[g*WND_W +: WND_W] <= wnd_reg[g*WND_W +: WND_W];
         always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) run_reg[g] <= '0;
            else if (pd_cyc[g]) begin
               if (!run_ok[g]) run_reg[g] <= '0;
               else if (run_reg[g] != {CNT_W{1'b1}}) run_reg[g] <= run_reg[g] + 1'b1;
            end
         end
      end
   endgenerate

   // Lock indications follow the running count
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         lock_reg <= '0;
         first_lock_o <= 1'b0;
         second_lock_o <= 1'b0;
      end else begin
         lock_reg[0] <= (run_reg[0] >= cnt1_reg);
         lock_reg[1] <= (run_reg[1] >= cnt2_reg);
         first_lock_o <= lock_reg[0];
         second_lock_o <= lock_reg[1];
      end
   end
   assign hold_exit = run_reg[0] >= cnth_reg;

   // Holdover entered by software, left on exit event
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) holdover_o <= 1'b0;
      else if (hold_exit) holdover_o <= 1'b0;
      else if (wr && paddr_i == A_CTRL && pwdata_i[CTRL_HOLD]) holdover_o <= 1'b1;
   end

   // Sticky events, cleared by reading, set wins
   assign ev = {dly_reg[DLY_HS] & resync_o, holdover_o & hold_exit, lock_reg[1] & ~second_lock_o,
      lock_reg[0] & ~first_lock_o};
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) irq_reg <= '0;
      else if (irq_clr) irq_reg <= ev;
      else irq_reg <= irq_reg | ev;
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) irq_o <= 1'b0;
      else irq_o <= |((irq_reg | ev) & mask_reg);
   end

   // Dynamic delay: count half steps of the distribution clock, then resync pulse
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         dst_reg <= DLY_IDLE;
         half_left_reg <= '0;
         resync_o <= 1'b0;
         qual_sel_o <= '0;
      end else begin
         resync_o <= 1'b0;
         case (dst_reg)
            DLY_IDLE: begin
               if (wr && paddr_i == A_CTRL && pwdata_i[CTRL_RESYNC]) begin
                  // Twice the count, less the half-step bit, in half periods
                  half_left_reg <= (DLY_W+2)'({dly_reg[DLY_W-1:0], 1'b0}) - (DLY_W+2)'(dly_reg[DLY_HS]);
                  qual_sel_o <= dly_reg[DLY_SEL +: SEL_W];
                  dst_reg <= DLY_WAIT;
               end
            end
            DLY_WAIT: begin
               if (half_left_reg == '0) dst_reg <= DLY_APPLY;
               else if (dist_tick) half_left_reg <= half_left_reg - 1'b1;
            end
            DLY_APPLY: begin
               // Single pulse; outputs keep running, repeated resync shifts again
               resync_o <= 1'b1;
               dst_reg <= DLY_IDLE;
            end
            default: dst_reg <= DLY_IDLE;
         endcase
      end
   end

   total_div_a: assert property (@(posedge clk_i) disable iff (rst_i)
      1'b1 |=> total_div_o == TOTAL_W'($past(presc_reg[PRESC_W-1:0])) * TOTAL_W'($past(fbdiv_reg[FBDIV_W-1:0])))
      else $error("total divide wrong");
   presc_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
      presc_reg >= PRESCALER_MIN && presc_reg <= PRESCALER_MAX) else $error("prescaler out of range");
   fbdiv_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
      fbdiv_reg >= FB_DIV_MIN && fbdiv_reg <= FB_DIV_MAX) else $error("divider out of range");
   cal_ignore_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ctrl_reg[CTRL_EXTVCO] |=> !div_err_o) else $error("cal divider not ignored");
   count_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      pd_cyc[0] && !run_ok[0] |=> run_reg[0] == '0) else $error("count not cleared");
   lock_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(first_lock_o) |-> $past(run_reg[0], 2) >= $past(cnt1_reg, 2)) else $error("early lock");
   lock_raise_a: assert property (@(posedge clk_i) disable iff (rst_i)
      run_reg[1] >= cnt2_reg && $stable(run_reg[1]) && $stable(cnt2_reg) |=> ##1 second_lock_o)
      else $error("lock not raised");
   lock_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
      run_reg[0] == '0 && cnt1_reg != '0 |=> ##1 !first_lock_o) else $error("lock not dropped");
   hold_exit_a: assert property (@(posedge clk_i) disable iff (rst_i)
      hold_exit |=> !holdover_o) else $error("holdover not left");
   events_three_a: assert property (@(posedge clk_i) disable iff (rst_i)
      holdover_o && hold_exit |=> irq_reg[2]) else $error("holdover exit event lost");
   resync_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
      resync_o |=> !resync_o) else $error("resync not single pulse");
   qual_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      dst_reg == DLY_WAIT |=> $stable(qual_sel_o)) else $error("qualifier changed");
   half_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
      dst_reg == DLY_WAIT && !dist_tick && half_left_reg != '0 |=> $stable(half_left_reg))
      else $error("delay counted without step");

   // Bus answer checks
   pready_setup_a: assert property (@(posedge clk_i) disable iff (rst_i)
      psel_i && !penable_i |=> pready_o)
      else $error("ready missing in access phase");

   pready_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
      pready_o |=> !pready_o)
      else $error("ready longer than one cycle");

   slverr_ready_a: assert property (@(posedge clk_i) disable iff (rst_i)
      pslverr_o |-> pready_o)
      else $error("error without ready");

   // Divider checks
   presc_refuse_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && paddr_i == A_PRESC && !in_range(pwdata_i, PRESCALER_MIN, PRESCALER_MAX) |=> $stable(presc_reg))
      else $error("prescaler write not refused");

   fbdiv_refuse_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && paddr_i == A_FBDIV && !in_range(pwdata_i, FB_DIV_MIN, FB_DIV_MAX) |=> $stable(fbdiv_reg))
      else $error("divider write not refused");

   caldiv_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
      caldiv_reg >= FB_DIV_MIN && caldiv_reg <= FB_DIV_MAX)
      else $error("cal divider out of range");

   // Detector checks
   count_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
      pd_cyc[0] && run_ok[0] && run_reg[0] != {CNT_W{1'b1}} |=> run_reg[0] == $past(run_reg[0]) + 1'b1)
      else $error("in-window cycle not counted");

   count_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !pd_cyc[0] |=> $stable(run_reg[0]))
      else $error("count moved without cycle");

   count2_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      pd_cyc[1] && !run_ok[1] |=> run_reg[1] == '0)
      else $error("second count not cleared");

   lock2_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(second_lock_o) |-> $past(run_reg[1], 2) >= $past(cnt2_reg, 2))
      else $error("early second lock");

   lock1_raise_a: assert property (@(posedge clk_i) disable iff (rst_i)
      run_reg[0] >= cnt1_reg && $stable(run_reg[0]) && $stable(cnt1_reg) |=> ##1 first_lock_o)
      else $error("first lock not raised");

   lock2_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
      run_reg[1] == '0 && cnt2_reg != '0 |=> ##1 !second_lock_o)
      else $error("second lock not dropped");

   hold_enter_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && paddr_i == A_CTRL && pwdata_i[CTRL_HOLD] && !hold_exit |=> holdover_o)
      else $error("holdover not entered");

   // Event checks
   irq_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
      irq_reg[0] && !irq_clr |=> irq_reg[0])
      else $error("event bit lost");

   irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
      1'b1 |=> irq_o == $past(|((irq_reg | ev) & mask_reg)))
      else $error("interrupt level wrong");

   // Delay checks
   delay_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
      dst_reg == DLY_IDLE && wr && paddr_i == A_CTRL && pwdata_i[CTRL_RESYNC] |=>
      half_left_reg == (DLY_W+2)'({$past(dly_reg[DLY_W-1:0]), 1'b0}) - (DLY_W+2)'($past(dly_reg[DLY_HS])))
      else $error("delay load wrong");

   qual_capture_a: assert property (@(posedge clk_i) disable iff (rst_i)
      dst_reg == DLY_IDLE && wr && paddr_i == A_CTRL && pwdata_i[CTRL_RESYNC] |=>
      qual_sel_o == $past(dly_reg[DLY_SEL +: SEL_W]))
      else $error("qualifier not captured");

   half_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
      dst_reg == DLY_WAIT && dist_tick && half_left_reg != '0 |=> half_left_reg == $past(half_left_reg) - 1'b1)
      else $error("half step not counted");

   wait_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
      dst_reg == DLY_WAIT && half_left_reg == '0 |=> dst_reg == DLY_APPLY)
      else $error("delay wait not ended");

   apply_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
      dst_reg == DLY_APPLY |=> resync_o)
      else $error("resync pulse missing");
endmodule

/* File: tb.sv */
// Purpose: Self-checking bench for the lock detector, divider check and dynamic delay
// Assumes: APB answers within 50 cycles; ticks spaced wider than the input sync delay
// Notes: Single clock at 125 MHz, no random stimulus
`timescale 1ns/10ps
module tb;
   import lock_delay_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0;
   logic [31:0] prdata_o, rd;
   logic pready_o, pslverr_o, se, first_lock_o, second_lock_o, holdover_o, div_err_o, resync_o, irq_o;
   logic [1:0] pd_tick_i = 2'b00;
   logic [2*WND_W-1:0] pd_err_i = 16'h0;
   logic dist_half_tick_i = 1'b0;
   logic [TOTAL_W-1:0] total_div_o;
   logic [SEL_W-1:0] qual_sel_o;
   int bad_count = 0;
   int compares = 0;
   int n;

   lock_delay u_dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .pd_tick_i(pd_tick_i), .pd_err_i(pd_err_i),
      .dist_half_tick_i(dist_half_tick_i), .first_lock_o(first_lock_o), .second_lock_o(second_lock_o),
      .holdover_o(holdover_o), .total_div_o(total_div_o), .div_err_o(div_err_o),
      .qual_sel_o(qual_sel_o), .resync_o(resync_o), .irq_o(irq_o));

   initial begin
      forever #4 clk_i = ~clk_i;
   end

   task automatic final_report;
      $display("Comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chkb(input string what, input logic exp, input logic got);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %b seen %b", what, exp, got);
      end
   endtask

   // Setup cycle, then access held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      n = 0;
      @(posedge clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i);
      while (pready_o !== 1'b1 && n < 50) begin
         n++;
         @(posedge clk_i);
      end
      rd = prdata_o;
      se = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask

   task automatic rreg(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, exp, rd);
   endtask

   // One phase-detector cycle of a loop with the given edge error
   task automatic tick(input int lp, input logic [7:0] err);
      @(posedge clk_i);
      pd_err_i[lp*WND_W +: WND_W] <= err;
      pd_tick_i[lp] <= ~pd_tick_i[lp];
      repeat (10) @(posedge clk_i);
   endtask

   // Counts distribution half ticks from the resync request to the pulse
   task automatic resync(input logic [9:0] cnt, input logic hs, input int exp_ticks);
      int seen;
      seen = 0;
      apb(1'b1, A_DELAY, {18'h0, 3'h5, hs, cnt});
      apb(1'b1, A_CTRL, 32'h4);
      for (int t = 1; t <= 30 && seen == 0; t++) begin
         @(posedge clk_i);
         dist_half_tick_i <= ~dist_half_tick_i;
         repeat (8) begin
            @(posedge clk_i);
            if (resync_o === 1'b1) seen = t;
         end
      end
      chk("resync half ticks", exp_ticks, seen);
      chk("qualifying select", 32'h5, {29'h0, qual_sel_o});
   endtask

   initial begin
      repeat (20000) @(posedge clk_i);
      bad_count++;
      final_report();
   end

   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rreg("irq after reset", A_IRQ, 32'h0);
      rreg("prescaler reset", A_PRESC, 32'h2);
      rreg("divider reset", A_FBDIV, 32'h1);
      chk("total reset", 32'h2, {9'h0, total_div_o});
      apb(1'b1, A_PRESC, 32'h9);
      apb(1'b1, A_PRESC, 32'h1);
      rreg("prescaler refused", A_PRESC, 32'h2);
      apb(1'b1, A_PRESC, 32'h8);
      rreg("prescaler max", A_PRESC, 32'h8);
      apb(1'b1, A_FBDIV, 32'h0);
      rreg("divider refused", A_FBDIV, 32'h1);
      apb(1'b1, A_FBDIV, 32'h403E7);
      rreg("divider max", A_FBDIV, 32'h403E7);
      rreg("total register", A_TOTAL, 32'h201F38);
      chk("total port", 32'h201F38, {9'h0, total_div_o});
      apb(1'b1, A_CALDIV, 32'h5);
      repeat (3) @(posedge clk_i);
      chkb("cal mismatch", 1'b1, div_err_o);
      apb(1'b1, A_CTRL, 32'h1);
      repeat (3) @(posedge clk_i);
      chkb("cal ignored ext", 1'b0, div_err_o);
      apb(1'b1, A_CTRL, 32'h0);
      apb(1'b1, A_CALDIV, 32'h403E7);
      repeat (3) @(posedge clk_i);
      chkb("cal equal", 1'b0, div_err_o);
      apb(1'b1, A_MASK, 32'h1);
      apb(1'b1, A_WND, 32'h0304);
      apb(1'b1, A_CNT1, 32'h3);
      tick(0, 8'h04);
      tick(0, 8'h02);
      chkb("lock1 early", 1'b0, first_lock_o);
      tick(0, 8'h00);
      chkb("lock1 set", 1'b1, first_lock_o);
      chkb("irq unmasked", 1'b1, irq_o);
      rreg("irq lock1", A_IRQ, 32'h1);
      repeat (2) @(posedge clk_i);
      chkb("irq cleared", 1'b0, irq_o);
      tick(0, 8'h05);
      chkb("lock1 drop", 1'b0, first_lock_o);
      tick(0, 8'h01);
      tick(0, 8'h01);
      chkb("lock1 restart", 1'b0, first_lock_o);
      apb(1'b1, A_MASK, 32'h0);
      apb(1'b1, A_CNT2, 32'h2);
      tick(1, 8'h04);
      tick(1, 8'h03);
      chkb("lock2 early", 1'b0, second_lock_o);
      tick(1, 8'h00);
      chkb("lock2 set", 1'b1, second_lock_o);
      chkb("irq masked", 1'b0, irq_o);
      rreg("irq lock2", A_IRQ, 32'h2);
      apb(1'b1, A_CNTH, 32'h4);
      apb(1'b1, A_CTRL, 32'h2);
      repeat (3) @(posedge clk_i);
      chkb("holdover on", 1'b1, holdover_o);
      tick(0, 8'h00);
      chkb("lock1 again", 1'b1, first_lock_o);
      chkb("holdover kept", 1'b1, holdover_o);
      tick(0, 8'h00);
      chkb("holdover exit", 1'b0, holdover_o);
      rreg("irq lock1 exit", A_IRQ, 32'h5);
      resync(10'h3, 1'b1, 5);
      resync(10'h3, 1'b1, 5);
      resync(10'h3, 1'b0, 6);
      // Zero offset for a qualifying divider of 10 is 13.5: count 14 with half step
      resync(10'h00E, 1'b1, 27);
      apb(1'b0, 8'h34, 32'h0);
      chkb("unmapped error", 1'b1, se);
      apb(1'b0, 8'h02, 32'h0);
      chkb("misaligned error", 1'b1, se);
      final_report();
   end
endmodule
